// ---- design/rxdw_map.svh ----
`ifndef RXDW_MAP_SVH
`define RXDW_MAP_SVH
// Descriptor first halfword bit positions
`define RXDW_B_EMPTY      15
`define RXDW_B_SW_A       14
`define RXDW_B_WRAP       13
`define RXDW_B_SW_B       12
`define RXDW_B_LAST       11
`define RXDW_B_MISS       8
`define RXDW_B_BCAST      7
`define RXDW_B_MCAST      6
`define RXDW_B_OVERSIZE   5
`define RXDW_B_PARTIAL    4
`define RXDW_B_RSV3       3
`define RXDW_B_CRC        2
`define RXDW_B_SPILL      1
`define RXDW_B_CUT        0
// Descriptor byte offsets
`define RXDW_OFS_CTRL     32'h0000_0000
`define RXDW_OFS_LEN      32'h0000_0002
`define RXDW_OFS_PTR_HI   32'h0000_0004
`define RXDW_OFS_PTR_LO   32'h0000_0006
`define RXDW_DESC_BYTES   32'h0000_0008
// Frame length ceiling and reported truncated length
`define RXDW_MAX_BYTES    16'h07ff
// Register offsets
`define RXDW_REG_CTRL     8'h00
`define RXDW_REG_RING     8'h04
`define RXDW_REG_BUFSZ    8'h08
`define RXDW_REG_MAXFL    8'h0c
`define RXDW_REG_KICK     8'h10
`define RXDW_REG_STATUS   8'h14
`define RXDW_REG_CUR      8'h18
// Reset values
`define RXDW_RST_BUFSZ    16'h0100
`define RXDW_RST_MAXFL    16'h05ee
`endif

// ---- design/rxdw_pkg.sv ----
package rxdw_pkg;
  // Per-frame summary handed over by the receive logic at frame end
  typedef struct packed {
    logic        addr_hit;
    logic        dest_bcast;
    logic        dest_mcast;
    logic        odd_bits;
    logic        crc_bad;
    logic        fifo_spill;
    logic [15:0] frame_len;
  } rxdw_frame_s;

  // Memory master request
  typedef struct packed {
    logic        wr;
    logic [31:0] addr;
    logic [15:0] wdata;
  } rxdw_mreq_s;

  typedef enum logic [2:0] {
    RXDW_IDLE   = 3'b000,
    RXDW_RD_CTL = 3'b001,
    RXDW_RD_PHI = 3'b010,
    RXDW_RD_PLO = 3'b011,
    RXDW_FILL   = 3'b100,
    RXDW_WR_LEN = 3'b101,
    RXDW_WR_CTL = 3'b110,
    RXDW_NEXT   = 3'b111
  } rxdw_state_e;
endpackage

// ---- design/rxdw_status_gen.sv ----
`timescale 1ns/10ps
`include "rxdw_map.svh"
// Builds the closing control halfword of a descriptor
module rxdw_status_gen (
  input  wire logic               is_last_i,
  input  wire logic               accept_all_i,
  input  wire logic               oversize_i,
  input  wire logic               cut_i,
  input  wire rxdw_pkg::rxdw_frame_s frm_i,
  input  wire logic [15:0]        old_ctl_i,
  output logic      [15:0]        ctl_o
);
  wire spill    = frm_i.fifo_spill;
  wire miss     = accept_all_i & ~frm_i.addr_hit & ~spill;
  wire partial  = frm_i.odd_bits & frm_i.crc_bad & ~spill;
  wire crc_fail = ~frm_i.odd_bits & frm_i.crc_bad & ~spill;
  wire ovs      = oversize_i & ~spill;

  // Software bits pass through; reserved bits close as zero
  always_comb
  begin
    ctl_o                  = 16'h0000;
    ctl_o[`RXDW_B_SW_A]    = old_ctl_i[`RXDW_B_SW_A];
    ctl_o[`RXDW_B_SW_B]    = old_ctl_i[`RXDW_B_SW_B];
    ctl_o[`RXDW_B_WRAP]    = old_ctl_i[`RXDW_B_WRAP];
    ctl_o[`RXDW_B_EMPTY]   = 1'b0;
    ctl_o[`RXDW_B_LAST]    = is_last_i;
    if (is_last_i)
    begin
      ctl_o[`RXDW_B_MISS]     = miss;
      ctl_o[`RXDW_B_BCAST]    = frm_i.dest_bcast;
      ctl_o[`RXDW_B_MCAST]    = frm_i.dest_mcast & ~frm_i.dest_bcast;
      ctl_o[`RXDW_B_OVERSIZE] = ovs;
      ctl_o[`RXDW_B_PARTIAL]  = partial;
      ctl_o[`RXDW_B_CRC]      = crc_fail;
      ctl_o[`RXDW_B_SPILL]    = spill;
      ctl_o[`RXDW_B_CUT]      = cut_i;
    end
    else
    begin
      // Status bits of an intermediate buffer keep what software left
      ctl_o[`RXDW_B_MISS:`RXDW_B_CUT] = old_ctl_i[`RXDW_B_MISS:`RXDW_B_CUT];
      ctl_o[`RXDW_B_RSV3]             = 1'b0;
    end
  end
endmodule

// ---- design/rxdw_engine.sv ----
`timescale 1ns/10ps
`include "rxdw_map.svh"
// Function
// - Close descriptor: empty, last, status, length
// - Status flags written only in last descriptor
// - Empty bit: software sets, device clears
// - Software-owned bits untouched and ignored
// - Wrap selects ring base, else consecutive
// - Last bit marks final buffer of frame
// - Miss flag under accept-all on address miss
// - Broadcast destination sets all-stations flag
// - Multicast but not broadcast sets group flag
// - Oversize flag when length exceeds limit
// - Partial byte with bad CRC, no CRC flag
// - CRC fail for whole-octet bad frames
// - FIFO spill zeroes other error flags
// - Cut short when frame over 2047 bytes
// - Length: buffer size or frame length, once
// - Buffer pointer read, never written
// - Empty-clear descriptor repolled once, then stop
// - At most 2047 bytes, truncated length 0x7FF
module rxdw_engine #(
  parameter int ADDR_W = 32
) (
  input  wire logic                  clk_i,
  input  wire logic                  srst_i,
  input  wire logic                  ce_i,
  // Register port
  input  wire logic [7:0]            reg_addr_i,
  input  wire logic [31:0]           reg_wdata_i,
  input  wire logic                  reg_wr_i,
  input  wire logic                  reg_rd_i,
  output logic      [31:0]           reg_rdata_o,
  // Receive data stream, one byte per beat
  input  wire logic                  rx_valid_i,
  input  wire logic [7:0]            rx_byte_i,
  output logic                       rx_ready_o,
  input  wire logic                  rx_end_i,
  input  wire rxdw_pkg::rxdw_frame_s rx_frame_i,
  // Halfword memory master, one request per cycle, read data next cycle
  output rxdw_pkg::rxdw_mreq_s       mem_req_o,
  output logic                       mem_req_vld_o,
  input  wire logic [15:0]           mem_rdata_i,
  output logic [ADDR_W-1:0]          dma_addr_o,
  output logic [7:0]                 dma_byte_o,
  output logic                       dma_wr_o,
  output logic                       stalled_o
);
  // Only a 32-bit pointer space is served by the walk logic
  if (ADDR_W != 32)
  begin : g_bad_addr_w
    $error("rxdw_engine: ADDR_W must be 32");
  end

  // ==========================================================
  // Registers
  logic                 enable_ff;
  logic                 accept_all_ff;
  logic [31:0]          ring_base_ff;
  logic [15:0]          buf_size_ff;
  logic [15:0]          frame_length_limit_ff;
  logic                 kick_ff;
  logic [31:0]          rdata_ff;

  wire wr_ctrl  = reg_wr_i & (reg_addr_i == `RXDW_REG_CTRL);
  wire wr_ring  = reg_wr_i & (reg_addr_i == `RXDW_REG_RING);
  wire wr_bufsz = reg_wr_i & (reg_addr_i == `RXDW_REG_BUFSZ);
  wire wr_maxfl = reg_wr_i & (reg_addr_i == `RXDW_REG_MAXFL);
  wire wr_kick  = reg_wr_i & (reg_addr_i == `RXDW_REG_KICK);

  // ==========================================================
  // Engine state
  rxdw_pkg::rxdw_state_e state_ff;
  rxdw_pkg::rxdw_state_e nxt_state;
  logic [31:0]          desc_ff;
  logic [15:0]          ctl_ff;
  logic [15:0]          ptr_hi_ff;
  logic [31:0]          wr_ptr_ff;
  logic [15:0]          buf_cnt_ff;
  logic [15:0]          frm_cnt_ff;
  logic                 repoll_ff;
  logic                 stalled_ff;
  logic                 closing_last_ff;
  logic                 cut_ff;
  rxdw_pkg::rxdw_frame_s frame_ff;
  logic                 rd_pend_ff;
  rxdw_pkg::rxdw_mreq_s mreq_ff;
  logic                 mreq_vld_ff;
  logic [7:0]           dbyte_ff;
  logic                 dwr_ff;
  logic [31:0]          daddr_ff;
  logic [15:0]          close_ctl;
  logic                 fill_rdy_ff;

  wire ctl_empty  = mem_rdata_i[`RXDW_B_EMPTY];
  wire frame_full = (frm_cnt_ff == `RXDW_MAX_BYTES);
  wire buf_full   = (buf_cnt_ff == buf_size_ff);
  // A byte moves only when ready and valid meet, so the source never loses one
  wire take_byte  = (state_ff == rxdw_pkg::RXDW_FILL) & rx_valid_i & fill_rdy_ff & ~buf_full;
  wire store_byte = take_byte & ~frame_full;
  wire plo_done   = (state_ff == rxdw_pkg::RXDW_RD_PLO) & rd_pend_ff;
  wire [15:0] nxt_buf_cnt = plo_done ? 16'h0000
                          : (store_byte ? buf_cnt_ff + 16'h0001 : buf_cnt_ff);
  wire end_frame  = (state_ff == rxdw_pkg::RXDW_FILL) & rx_end_i & ~rx_valid_i;
  wire [31:0] next_seq = desc_ff + `RXDW_DESC_BYTES;
  wire [31:0] next_desc = ctl_ff[`RXDW_B_WRAP] ? ring_base_ff : next_seq;
  wire [15:0] len_word = closing_last_ff
                       ? (cut_ff ? `RXDW_MAX_BYTES : frame_ff.frame_len)
                       : buf_size_ff;

  // Closing halfword generator
  rxdw_status_gen u_status (
    .is_last_i    (closing_last_ff),
    .accept_all_i (accept_all_ff),
    .oversize_i   (frame_ff.frame_len > frame_length_limit_ff),
    .cut_i        (cut_ff),
    .frm_i        (frame_ff),
    .old_ctl_i    (ctl_ff),
    .ctl_o        (close_ctl)
  );

  // Next state; reads only advance when the previous read has returned
  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      rxdw_pkg::RXDW_IDLE:   if (kick_ff & ~rd_pend_ff) nxt_state = rxdw_pkg::RXDW_RD_CTL;
      rxdw_pkg::RXDW_RD_CTL:
        if (rd_pend_ff)
        begin
          if (ctl_empty)
            nxt_state = rxdw_pkg::RXDW_RD_PHI;
          else if (repoll_ff)
            nxt_state = rxdw_pkg::RXDW_IDLE;
        end
      rxdw_pkg::RXDW_RD_PHI: if (rd_pend_ff) nxt_state = rxdw_pkg::RXDW_RD_PLO;
      rxdw_pkg::RXDW_RD_PLO: if (rd_pend_ff) nxt_state = rxdw_pkg::RXDW_FILL;
      rxdw_pkg::RXDW_FILL:   if (end_frame | (buf_full & rx_valid_i))
                               nxt_state = rxdw_pkg::RXDW_WR_LEN;
      rxdw_pkg::RXDW_WR_LEN: nxt_state = rxdw_pkg::RXDW_WR_CTL;
      rxdw_pkg::RXDW_WR_CTL: nxt_state = rxdw_pkg::RXDW_NEXT;
      rxdw_pkg::RXDW_NEXT:   nxt_state = rxdw_pkg::RXDW_RD_CTL;
      default:               nxt_state = rxdw_pkg::RXDW_IDLE;
    endcase
  end

  // Control and configuration registers
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      enable_ff     <= 1'b0;
      accept_all_ff <= 1'b0;
      ring_base_ff  <= 32'h0000_0000;
      buf_size_ff   <= `RXDW_RST_BUFSZ;
      frame_length_limit_ff     <= `RXDW_RST_MAXFL;
    end
    else if (ce_i)
    begin
      if (wr_ctrl)
      begin
        enable_ff     <= reg_wdata_i[0];
        accept_all_ff <= reg_wdata_i[1];
      end
      if (wr_ring)
        ring_base_ff <= {reg_wdata_i[31:2], 2'b00};
      if (wr_bufsz)
        buf_size_ff <= {reg_wdata_i[15:4], 4'h0};
      if (wr_maxfl)
        frame_length_limit_ff <= reg_wdata_i[15:0];
    end
  end

  // Kick flag: a new kick wins over the engine's own clear
  always_ff @(posedge clk_i)
  begin
    if (srst_i | ~enable_ff)
      kick_ff <= 1'b0;
    else if (ce_i)
      kick_ff <= wr_kick | (kick_ff & ~(state_ff == rxdw_pkg::RXDW_IDLE & ~rd_pend_ff));
  end

  // Read data, one cycle after the strobe
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
      rdata_ff <= 32'h0000_0000;
    else if (ce_i)
    begin
      rdata_ff <= 32'h0000_0000;
      if (reg_rd_i)
        case (reg_addr_i)
          `RXDW_REG_CTRL:   rdata_ff <= {30'h0, accept_all_ff, enable_ff};
          `RXDW_REG_RING:   rdata_ff <= ring_base_ff;
          `RXDW_REG_BUFSZ:  rdata_ff <= {16'h0, buf_size_ff};
          `RXDW_REG_MAXFL:  rdata_ff <= {16'h0, frame_length_limit_ff};
          `RXDW_REG_STATUS: rdata_ff <= {13'h0, state_ff, 15'h0, stalled_ff};
          `RXDW_REG_CUR:    rdata_ff <= desc_ff;
          default:          rdata_ff <= 32'h0000_0000;
        endcase
    end
  end

  // Descriptor walk; clearing enable returns the pointer to the ring base
  always_ff @(posedge clk_i)
  begin
    if (srst_i | ~enable_ff)
    begin
      state_ff        <= rxdw_pkg::RXDW_IDLE;
      desc_ff         <= ring_base_ff;
      repoll_ff       <= 1'b0;
      stalled_ff      <= 1'b0;
      rd_pend_ff      <= 1'b0;
      closing_last_ff <= 1'b0;
    end
    else if (ce_i)
    begin
      state_ff <= nxt_state;
      if (state_ff == rxdw_pkg::RXDW_IDLE && kick_ff)
      begin
        stalled_ff <= 1'b0;
        repoll_ff  <= 1'b0;
      end
      rd_pend_ff <= mreq_vld_ff ? ~mreq_ff.wr : 1'b0;
      // An empty descriptor ends a poll run, so the next one gets two polls again
      if (state_ff == rxdw_pkg::RXDW_RD_CTL && rd_pend_ff && ctl_empty)
        repoll_ff <= 1'b0;
      if (state_ff == rxdw_pkg::RXDW_RD_CTL && rd_pend_ff && !ctl_empty)
      begin
        repoll_ff  <= ~repoll_ff;
        stalled_ff <= repoll_ff;
      end
      if (state_ff == rxdw_pkg::RXDW_FILL)
        closing_last_ff <= end_frame;
      if (state_ff == rxdw_pkg::RXDW_NEXT)
        desc_ff <= next_desc;
    end
  end

  // Descriptor contents, byte counters and frame summary
  always_ff @(posedge clk_i)
  begin
    if (srst_i | ~enable_ff)
    begin
      ctl_ff     <= 16'h0000;
      ptr_hi_ff  <= 16'h0000;
      wr_ptr_ff  <= 32'h0000_0000;
      buf_cnt_ff <= 16'h0000;
      frm_cnt_ff <= 16'h0000;
      cut_ff     <= 1'b0;
      frame_ff   <= '0;
    end
    else if (ce_i)
    begin
      if (state_ff == rxdw_pkg::RXDW_RD_CTL && rd_pend_ff)
        ctl_ff <= mem_rdata_i;
      if (state_ff == rxdw_pkg::RXDW_RD_PHI && rd_pend_ff)
        ptr_hi_ff <= mem_rdata_i;
      if (state_ff == rxdw_pkg::RXDW_RD_PLO && rd_pend_ff)
      begin
        wr_ptr_ff  <= {ptr_hi_ff, mem_rdata_i};
        buf_cnt_ff <= 16'h0000;
      end
      if (take_byte)
      begin
        if (store_byte)
        begin
          wr_ptr_ff  <= wr_ptr_ff + 32'h0000_0001;
          buf_cnt_ff <= buf_cnt_ff + 16'h0001;
          frm_cnt_ff <= frm_cnt_ff + 16'h0001;
        end
        else
          cut_ff <= 1'b1;
      end
      if (end_frame)
        frame_ff <= rx_frame_i;
      if (state_ff == rxdw_pkg::RXDW_WR_CTL && closing_last_ff)
      begin
        frm_cnt_ff <= 16'h0000;
        cut_ff     <= 1'b0;
      end
    end
  end

  // Memory requests: descriptor reads, then length and control on close
  always_ff @(posedge clk_i)
  begin
    if (srst_i | ~enable_ff)
    begin
      mreq_ff     <= '0;
      mreq_vld_ff <= 1'b0;
      dbyte_ff    <= 8'h00;
      dwr_ff      <= 1'b0;
      daddr_ff    <= 32'h0000_0000;
    end
    else if (ce_i)
    begin
      mreq_vld_ff <= 1'b0;
      mreq_ff.wr  <= 1'b0;
      if (nxt_state != state_ff || (state_ff == rxdw_pkg::RXDW_RD_CTL && rd_pend_ff))
      begin
        case (nxt_state)
          rxdw_pkg::RXDW_RD_CTL:
          begin
            mreq_ff     <= '{wr: 1'b0, addr: (state_ff == rxdw_pkg::RXDW_NEXT ? next_desc
                                                 : desc_ff) + `RXDW_OFS_CTRL, wdata: 16'h0};
            mreq_vld_ff <= 1'b1;
          end
          rxdw_pkg::RXDW_RD_PHI:
          begin
            mreq_ff     <= '{wr: 1'b0, addr: desc_ff + `RXDW_OFS_PTR_HI, wdata: 16'h0};
            mreq_vld_ff <= 1'b1;
          end
          rxdw_pkg::RXDW_RD_PLO:
          begin
            mreq_ff     <= '{wr: 1'b0, addr: desc_ff + `RXDW_OFS_PTR_LO, wdata: 16'h0};
            mreq_vld_ff <= 1'b1;
          end
          rxdw_pkg::RXDW_WR_CTL:
          begin
            mreq_ff     <= '{wr: 1'b1, addr: desc_ff + `RXDW_OFS_LEN, wdata: len_word};
            mreq_vld_ff <= 1'b1;
          end
          rxdw_pkg::RXDW_NEXT:
          begin
            mreq_ff     <= '{wr: 1'b1, addr: desc_ff + `RXDW_OFS_CTRL, wdata: close_ctl};
            mreq_vld_ff <= 1'b1;
          end
          default:
            mreq_vld_ff <= 1'b0;
        endcase
      end
      // Data bytes go straight out; the pointer alignment is software's duty
      dwr_ff   <= store_byte;
      dbyte_ff <= rx_byte_i;
      daddr_ff <= wr_ptr_ff;
    end
  end

  // Outputs straight from flip-flops
  assign reg_rdata_o   = rdata_ff;
  assign mem_req_o     = mreq_ff;
  assign mem_req_vld_o = mreq_vld_ff;
  assign dma_addr_o    = daddr_ff;
  assign dma_byte_o    = dbyte_ff;
  assign dma_wr_o      = dwr_ff;
  assign stalled_o     = stalled_ff;
  assign rx_ready_o    = fill_rdy_ff;

  // Ready registered one cycle ahead from the next count, so it is never
  // high while the buffer is full; source holds data until seen ready
  always_ff @(posedge clk_i)
  begin
    if (srst_i | ~enable_ff)
      fill_rdy_ff <= 1'b0;
    else if (ce_i)
      fill_rdy_ff <= (nxt_state == rxdw_pkg::RXDW_FILL) & (nxt_buf_cnt != buf_size_ff);
  end
endmodule

// ---- tb/rxdw_engine_properties.sv ----
`timescale 1ns/10ps
// ==========
// Descriptor write-back checker
module rxdw_engine_chk (
  input  wire logic                 clk_i,
  input  wire logic                 srst_i,
  input  wire rxdw_pkg::rxdw_mreq_s mem_req_o,
  input  wire logic                 mem_req_vld_o,
  input  wire logic [15:0]          mem_rdata_i,
  input  wire logic                 stalled_o
);
  logic        rd_ctl_ff;
  logic [15:0] seen_ff;
  logic [1:0]  poll_ff;
  // Request decode on the halfword master
  wire         wr_v  = mem_req_vld_o && mem_req_o.wr;
  wire         ctl_w = wr_v && mem_req_o.addr[2:0] == 3'h0;
  wire         len_w = wr_v && mem_req_o.addr[2:0] == 3'h2;
  wire  [15:0] wd    = mem_req_o.wdata;

  // Last fetched control halfword and run of empty-clear polls, saturating
  always_ff @(posedge clk_i)
  begin
    rd_ctl_ff <= !srst_i && mem_req_vld_o && !mem_req_o.wr && mem_req_o.addr[2:0] == 3'h0;
    if (srst_i)
      poll_ff <= 2'h0;
    else if (rd_ctl_ff)
      poll_ff <= mem_rdata_i[15] ? 2'h0 : poll_ff + {1'b0, poll_ff != 2'h3};
    if (rd_ctl_ff)
      seen_ff <= mem_rdata_i;
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);

  // ==========
  // Properties
  property p_ptr_ro;
    wr_v |-> !mem_req_o.addr[2];
  endproperty
  a_ptr_ro: assert property (p_ptr_ro)
    else $error("pointer halfword written");
  property p_close;
    ctl_w |-> !wd[15] && wd[10:9] == 2'h0 && !wd[3];
  endproperty
  a_close: assert property (p_close)
    else $error("closing halfword not clean");
  property p_partial;
    ctl_w && wd[4] |-> !wd[2];
  endproperty
  a_partial: assert property (p_partial)
    else $error("partial byte with crc flag");
  property p_spill;
    ctl_w && wd[1] |-> (wd & 16'h0134) == 16'h0;
  endproperty
  a_spill: assert property (p_spill)
    else $error("spill left error flags");
  property p_len;
    len_w |-> wd <= 16'h07ff;
  endproperty
  a_len: assert property (p_len)
    else $error("length above ceiling");
  property p_pair;
    len_w |=> ##[0:3] ctl_w;
  endproperty
  a_pair: assert property (p_pair)
    else $error("length not followed by close");
  property p_keep;
    ctl_w && !wd[11] |-> wd[8:0] == (seen_ff[8:0] & 9'h1f7);
  endproperty
  a_keep: assert property (p_keep)
    else $error("status changed in non-last");
  property p_sw;
    ctl_w |-> wd[14] == seen_ff[14] && wd[12] == seen_ff[12];
  endproperty
  a_sw: assert property (p_sw)
    else $error("software bits changed");
  property p_stall;
    $rose(stalled_o) |-> poll_ff >= 2'h2;
  endproperty
  a_stall: assert property (p_stall)
    else $error("stall without second poll");
  property p_quiet;
    stalled_o && $past(stalled_o) |-> !mem_req_vld_o;
  endproperty
  a_quiet: assert property (p_quiet)
    else $error("fetch while stalled");
endmodule

bind rxdw_engine rxdw_engine_chk u_chk (
  .clk_i         (clk_i),
  .srst_i        (srst_i),
  .mem_req_o     (mem_req_o),
  .mem_req_vld_o (mem_req_vld_o),
  .mem_rdata_i   (mem_rdata_i),
  .stalled_o     (stalled_o)
);

// ---- tb/rxdw_mem_model.sv ----
`timescale 1ns/10ps
// ==========
// Ring and buffer memory behind the receive DMA
module rxdw_mem_model (
  input  wire logic                 clk_i,
  input  wire rxdw_pkg::rxdw_mreq_s req_i,
  input  wire logic                 vld_i,
  input  wire logic [31:0]          addr_i,
  input  wire logic [7:0]           byte_i,
  input  wire logic                 wr_i,
  output logic      [15:0]          rdata_o
);
  logic [15:0] m [int];
  logic [7:0]  b [int];

  // Read data stand one cycle; after that the lines flip so stale data never match
  always @(posedge clk_i)
  begin
    if (vld_i && req_i.wr)
      m[int'(req_i.addr[31:1])] = req_i.wdata;
    if (vld_i && !req_i.wr)
      rdata_o <= m.exists(int'(req_i.addr[31:1])) ? m[int'(req_i.addr[31:1])] : 16'h0;
    else
      rdata_o <= ~rdata_o;
    if (wr_i)
      b[int'(addr_i)] = byte_i;
  end
endmodule

// ---- tb/rxdw_tb.sv ----
`timescale 1ns/10ps
// ==========
// Receive descriptor write-back bench
module testbench;
  logic                  clk_i = 1'b0;
  logic                  srst_i = 1'b1;
  logic                  ce_i = 1'b1;
  logic [7:0]            reg_addr_i = 8'h0;
  logic [31:0]           reg_wdata_i = 32'h0;
  logic                  reg_wr_i = 1'b0;
  logic                  reg_rd_i = 1'b0;
  logic [31:0]           reg_rdata_o;
  logic                  rx_valid_i = 1'b0;
  logic [7:0]            rx_byte_i = 8'h0;
  logic                  rx_ready_o;
  logic                  rx_end_i = 1'b0;
  rxdw_pkg::rxdw_frame_s rx_frame_i = '0;
  rxdw_pkg::rxdw_mreq_s  mem_req_o;
  logic                  mem_req_vld_o;
  logic [15:0]           mem_rdata_i;
  logic [31:0]           dma_addr_o;
  logic [7:0]            dma_byte_o;
  logic                  dma_wr_o;
  logic                  stalled_o;
  int                    n_errors = 0;
  int                    checks = 0;

  always #2.5 clk_i = ~clk_i;

  rxdw_engine DUT (
    .clk_i(clk_i), .srst_i(srst_i), .ce_i(ce_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .rx_valid_i(rx_valid_i), .rx_byte_i(rx_byte_i), .rx_ready_o(rx_ready_o),
    .rx_end_i(rx_end_i), .rx_frame_i(rx_frame_i),
    .mem_req_o(mem_req_o), .mem_req_vld_o(mem_req_vld_o), .mem_rdata_i(mem_rdata_i),
    .dma_addr_o(dma_addr_o), .dma_byte_o(dma_byte_o), .dma_wr_o(dma_wr_o),
    .stalled_o(stalled_o));
  rxdw_mem_model mm (.clk_i(clk_i), .req_i(mem_req_o), .vld_i(mem_req_vld_o),
    .addr_i(dma_addr_o), .byte_i(dma_byte_o), .wr_i(dma_wr_o), .rdata_o(mem_rdata_i));

  // ==========
  // Shared tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic end_sim();
    if (n_errors == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    reg_wr_i    <= 1'b1;
    @(posedge clk_i);
    reg_wr_i    <= 1'b0;
  endtask

  // Read data are looked at only in the cycle after the strobe
  task automatic reg_rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_rd_i   <= 1'b1;
    @(posedge clk_i);
    reg_rd_i   <= 1'b0;
    #1 chk(reg_rdata_o, exp);
  endtask

  // Software arms a descriptor; buffers sit on 16-byte boundaries
  task automatic desc(input int a, input logic [15:0] c, input logic [31:0] p);
    mm.m[a/2]   = c;
    mm.m[a/2+2] = p[31:16];
    mm.m[a/2+3] = p[15:0];
  endtask

  // Bytes a0, a1, ... held until taken, then the frame-end pulse with valid low
  task automatic frame(input int n, input rxdw_pkg::rxdw_frame_s f);
    int k;
    for (int i = 0; i < n; i++)
    begin
      rx_valid_i <= 1'b1;
      rx_byte_i  <= 8'(8'ha0 + i);
      k = 0;
      do
      begin
        @(negedge clk_i);
        k++;
      end
      while (!rx_ready_o && k < 200);
      if (k == 200)
      begin
        chk(32'h1, 32'h0);
        end_sim();
      end
      @(posedge clk_i);
    end
    rx_valid_i <= 1'b0;
    rx_end_i   <= 1'b1;
    rx_frame_i <= f;
    @(posedge clk_i);
    rx_end_i   <= 1'b0;
  endtask

  task automatic wait_close(input int a);
    int k;
    k = 0;
    while (mm.m[a/2][15] !== 1'b0 && k < 400)
    begin
      @(negedge clk_i);
      k++;
    end
    if (k == 400)
    begin
      chk(32'h1, 32'h0);
      end_sim();
    end
  endtask

  // ==========
  // Scenarios; frame bits: hit, bcast, mcast, odd, crc, spill
  task automatic t_single();
    desc(32'h100, 16'hc000, 32'h2000);
    desc(32'h108, 16'h9081, 32'h2100);
    desc(32'h110, 16'ha000, 32'h2200);
    reg_wr(8'h04, 32'h100);
    reg_wr(8'h00, 32'h1);
    reg_wr(8'h10, 32'h1);
    frame(8, {6'b110010, 16'h0008});
    wait_close(32'h100);
    chk(mm.m[16'h80], 16'h4884);
    chk(mm.m[16'h81], 16'h0008);
    chk(mm.m[16'h82], 16'h0000);
    chk(mm.b[32'h2007], 8'ha7);
  endtask

  // Two buffers, accept-all on, spill hides error flags, wrap ends the ring
  task automatic t_multi();
    reg_wr(8'h00, 32'h3);
    frame(20, {6'b001111, 16'h0014});
    wait_close(32'h110);
    chk(mm.m[16'h84], 16'h1081);
    chk(mm.m[16'h85], 16'h0010);
    chk(mm.m[16'h88], 16'h2842);
    chk(mm.m[16'h89], 16'h0014);
    chk(mm.b[32'h2200], 8'hb0);
  endtask

  // Wrap returns to the closed first descriptor: poll twice, then stop
  task automatic t_stall();
    int k;
    k = 0;
    while (stalled_o !== 1'b1 && k < 100)
    begin
      @(negedge clk_i);
      k++;
    end
    chk(stalled_o, 1'b1);
    chk(mm.m[16'h80], 16'h4884);
    if (k == 100)
      end_sim();
  endtask

  // Kick resumes; miss, oversize and partial byte on one frame
  task automatic t_flags();
    reg_wr(8'h0c, 32'h8);
    desc(32'h100, 16'h8000, 32'h2000);
    reg_wr(8'h10, 32'h1);
    frame(9, {6'b000110, 16'h0009});
    wait_close(32'h100);
    chk(mm.m[16'h80], 16'h0930);
    chk(mm.m[16'h81], 16'h0009);
  endtask

  // Over-long frame: bytes past the ceiling dropped, length pinned, cut flag set
  task automatic t_cut();
    reg_wr(8'h08, 32'h800);
    desc(32'h108, 16'ha000, 32'h3000);
    reg_wr(8'h10, 32'h1);
    frame(2050, {6'b100000, 16'h0802});
    wait_close(32'h108);
    chk(mm.m[16'h84], 16'h2821);
    chk(mm.m[16'h85], 16'h07ff);
    chk(mm.b[32'h37fe], 8'h9e);
    chk(mm.b.exists(32'h37ff), 1'b0);
  endtask

  // ==========
  // Main sequence
  initial
  begin
    repeat (6) @(posedge clk_i);
    srst_i <= 1'b0;
    reg_wr(8'h08, 32'h10);
    // Clock enable low: a write in that cycle must leave the register alone
    ce_i <= 1'b0;
    reg_wr(8'h08, 32'h20);
    ce_i <= 1'b1;
    reg_rd(8'h08, 32'h10);
    reg_rd(8'h1c, 32'h0);
    t_single();
    t_multi();
    t_stall();
    t_flags();
    t_cut();
    end_sim();
  end
endmodule
